//--- rtl/hub_power_and_string_config_bank.sv
`timescale 1ns/1ps
`default_nettype none

module hub_power_and_string_config_bank (
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    input  wire cfg_bank_pkg::cfg_wr_t   cfg_wr_in,
    input  wire logic [7:0]              cfg_rd_addr_in,
    output logic [7:0]                   cfg_rd_data_out,
    input  wire logic                    port_power_start_in,
    output logic                         port_power_busy_out,
    output logic                         port_power_stable_out,
    output cfg_bank_pkg::cfg_view_t      cfg_view_out,
    input  wire logic                    text_req_in,
    input  wire logic                    text_ready_in,
    output logic                         text_valid_out,
    output logic [15:0]                  text_char_out,
    output logic                         text_last_out
);

    logic [7:0] current_r;
    logic [7:0] current_nxt;
    logic [7:0] settle_r;
    logic [7:0] settle_nxt;
    logic [7:0] lang_high_r;
    logic [7:0] lang_high_nxt;
    logic [7:0] lang_low_r;
    logic [7:0] lang_low_nxt;
    logic [7:0] maker_len_r;
    logic [7:0] maker_len_nxt;
    logic [7:0] prod_len_r;
    logic [7:0] prod_len_nxt;
    logic [7:0] serial_len_r;
    logic [7:0] serial_len_nxt;
    logic [7:0] text_r   [cfg_bank_pkg::TEXT_BYTES];
    logic [7:0] text_nxt [cfg_bank_pkg::TEXT_BYTES];
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01
    } send_state_t;

    send_state_t state_r;
    send_state_t state_nxt;
    logic [4:0]  char_idx_r;
    logic [4:0]  char_idx_nxt;
    logic [4:0]  char_cnt_r;
    logic [4:0]  char_cnt_nxt;
    logic [15:0] char_r;
    logic [15:0] char_nxt;

    function automatic logic in_text(input logic [7:0] a);
        in_text = (a >= cfg_bank_pkg::OFS_TEXT_FIRST) && (a <= cfg_bank_pkg::OFS_TEXT_LAST);
    endfunction

    function automatic logic [5:0] text_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - cfg_bank_pkg::OFS_TEXT_FIRST;
        text_index = d[5:0];
    endfunction

    // Two stored bytes form one character, low byte first
    function automatic logic [15:0] fetch_char(input logic [7:0] lo, input logic [7:0] hi);
        fetch_char = {hi, lo};
    endfunction

    // Length over 31 is clamped; storage holds no more
    function automatic logic [4:0] clamp_len(input logic [7:0] n);
        clamp_len = (n > 8'(cfg_bank_pkg::TEXT_MAX_CHARS)) ? cfg_bank_pkg::TEXT_MAX_CHARS
                                                           : n[4:0];
    endfunction

    // ==========================================================
    // Register writes and reads
    // ==========================================================
    always_comb
    begin
        current_nxt    = current_r;
        settle_nxt     = settle_r;
        lang_high_nxt  = lang_high_r;
        lang_low_nxt   = lang_low_r;
        maker_len_nxt  = maker_len_r;
        prod_len_nxt   = prod_len_r;
        serial_len_nxt = serial_len_r;
        for (int i = 0; i < cfg_bank_pkg::TEXT_BYTES; i++)
        begin
            text_nxt[i] = text_r[i];
        end
        if (cfg_wr_in.wr)
        begin
            case (cfg_wr_in.addr)
                cfg_bank_pkg::OFS_CURRENT:    current_nxt    = cfg_wr_in.data;
                cfg_bank_pkg::OFS_SETTLE:     settle_nxt     = cfg_wr_in.data;
                cfg_bank_pkg::OFS_LANG_HIGH:  lang_high_nxt  = cfg_wr_in.data;
                cfg_bank_pkg::OFS_LANG_LOW:   lang_low_nxt   = cfg_wr_in.data;
                cfg_bank_pkg::OFS_MAKER_LEN:  maker_len_nxt  = cfg_wr_in.data;
                cfg_bank_pkg::OFS_PROD_LEN:   prod_len_nxt   = cfg_wr_in.data;
                cfg_bank_pkg::OFS_SERIAL_LEN: serial_len_nxt = cfg_wr_in.data;
                default:
                begin
                    if (in_text(cfg_wr_in.addr))
                    begin
                        text_nxt[text_index(cfg_wr_in.addr)] = cfg_wr_in.data;
                    end
                end
            endcase
        end

        case (cfg_rd_addr_in)
            cfg_bank_pkg::OFS_CURRENT:    rd_data_nxt = current_r;
            cfg_bank_pkg::OFS_SETTLE:     rd_data_nxt = settle_r;
            cfg_bank_pkg::OFS_LANG_HIGH:  rd_data_nxt = lang_high_r;
            cfg_bank_pkg::OFS_LANG_LOW:   rd_data_nxt = lang_low_r;
            cfg_bank_pkg::OFS_MAKER_LEN:  rd_data_nxt = maker_len_r;
            cfg_bank_pkg::OFS_PROD_LEN:   rd_data_nxt = prod_len_r;
            cfg_bank_pkg::OFS_SERIAL_LEN: rd_data_nxt = serial_len_r;
            default:
            begin
                // Unmapped offsets read zero
                rd_data_nxt = in_text(cfg_rd_addr_in) ? text_r[text_index(cfg_rd_addr_in)]
                                                      : 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            current_r    <= cfg_bank_pkg::RST_CURRENT;
            settle_r     <= cfg_bank_pkg::RST_ZERO;
            lang_high_r  <= cfg_bank_pkg::RST_ZERO;
            lang_low_r   <= cfg_bank_pkg::RST_ZERO;
            maker_len_r  <= cfg_bank_pkg::RST_ZERO;
            prod_len_r   <= cfg_bank_pkg::RST_ZERO;
            serial_len_r <= cfg_bank_pkg::RST_ZERO;
            rd_data_r    <= cfg_bank_pkg::RST_ZERO;
            for (int i = 0; i < cfg_bank_pkg::TEXT_BYTES; i++)
            begin
                text_r[i] <= cfg_bank_pkg::RST_ZERO;
            end
        end
        else
        begin
            current_r    <= current_nxt;
            settle_r     <= settle_nxt;
            lang_high_r  <= lang_high_nxt;
            lang_low_r   <= lang_low_nxt;
            maker_len_r  <= maker_len_nxt;
            prod_len_r   <= prod_len_nxt;
            serial_len_r <= serial_len_nxt;
            rd_data_r    <= rd_data_nxt;
            for (int i = 0; i < cfg_bank_pkg::TEXT_BYTES; i++)
            begin
                text_r[i] <= text_nxt[i];
            end
        end
    end

    assign cfg_rd_data_out = rd_data_r;

    // ==========================================================
    // Decoded view for descriptor and power logic
    // ==========================================================
    always_comb
    begin
        cfg_view_out.current_units = current_r;
        cfg_view_out.current_ma    = {1'b0, current_r, 1'b0};
        cfg_view_out.settle_units  = settle_r;
        cfg_view_out.language_id   = {lang_high_r, lang_low_r};
        cfg_view_out.maker_len     = maker_len_r;
        cfg_view_out.product_len   = prod_len_r;
        cfg_view_out.serial_len    = serial_len_r;
    end

    // ==========================================================
    // Port power settle timer
    // ==========================================================
    settle_timer u_settle (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .start_in   (port_power_start_in),
        .units_in   (settle_r),
        .busy_out   (port_power_busy_out),
        .stable_out (port_power_stable_out)
    );

    // ==========================================================
    // Maker string streamer
    // ==========================================================
    always_comb
    begin
        state_nxt    = state_r;
        char_idx_nxt = char_idx_r;
        char_cnt_nxt = char_cnt_r;
        char_nxt     = char_r;
        case (state_r)
            ST_IDLE:
            begin
                if (text_req_in && (clamp_len(maker_len_r) != 5'h00))
                begin
                    state_nxt    = ST_SEND;
                    char_idx_nxt = 5'h00;
                    char_cnt_nxt = clamp_len(maker_len_r);
                    char_nxt     = fetch_char(text_r[0], text_r[1]);
                end
            end
            ST_SEND:
            begin
                if (text_ready_in)
                begin
                    if (char_idx_r + 5'h01 == char_cnt_r)
                    begin
                        state_nxt = ST_IDLE;
                    end
                    else
                    begin
                        char_idx_nxt = char_idx_r + 5'h01;
                        char_nxt     = fetch_char(text_r[{char_idx_nxt, 1'b0}],
                                                  text_r[{char_idx_nxt, 1'b1}]);
                    end
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_r    <= ST_IDLE;
            char_idx_r <= 5'h00;
            char_cnt_r <= 5'h00;
            char_r     <= 16'h0000;
        end
        else
        begin
            state_r    <= state_nxt;
            char_idx_r <= char_idx_nxt;
            char_cnt_r <= char_cnt_nxt;
            char_r     <= char_nxt;
        end
    end

    assign text_valid_out = (state_r == ST_SEND);
    assign text_char_out  = char_r;
    assign text_last_out  = (state_r == ST_SEND) && (char_idx_r + 5'h01 == char_cnt_r);

endmodule
`default_nettype wire

//--- pkg/cfg_bank_pkg.sv
`default_nettype none

package cfg_bank_pkg;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] OFS_CURRENT    = 8'h0f;
    localparam logic [7:0] OFS_SETTLE     = 8'h10;
    localparam logic [7:0] OFS_LANG_HIGH  = 8'h11;
    localparam logic [7:0] OFS_LANG_LOW   = 8'h12;
    localparam logic [7:0] OFS_MAKER_LEN  = 8'h13;
    localparam logic [7:0] OFS_PROD_LEN   = 8'h14;
    localparam logic [7:0] OFS_SERIAL_LEN = 8'h15;
    localparam logic [7:0] OFS_TEXT_FIRST = 8'h16;
    localparam logic [7:0] OFS_TEXT_LAST  = 8'h53;

    // ==========================================================
    // Sizes and reset values
    // ==========================================================
    localparam int         TEXT_BYTES      = 62;
    localparam logic [4:0] TEXT_MAX_CHARS  = 5'h1f;
    localparam logic [7:0] RST_CURRENT     = 8'h32;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam int         CURRENT_UNIT_MA = 2;
    localparam int         SETTLE_UNIT_MS  = 2;
    localparam int         CLK_HZ          = 20000000;
    // Cycles per 2 ms settle unit
    localparam int         SETTLE_UNIT_CYC = (CLK_HZ / 1000) * SETTLE_UNIT_MS;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } cfg_wr_t;

    typedef struct packed {
        logic [7:0]  current_units;
        logic [9:0]  current_ma;
        logic [7:0]  settle_units;
        logic [15:0] language_id;
        logic [7:0]  maker_len;
        logic [7:0]  product_len;
        logic [7:0]  serial_len;
    } cfg_view_t;

endpackage
`default_nettype wire

//--- rtl/settle_timer.sv
`timescale 1ns/1ps
`default_nettype none

module settle_timer #(
    parameter int UNIT_CYC = cfg_bank_pkg::SETTLE_UNIT_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       start_in,
    input  wire logic [7:0] units_in,
    output logic            busy_out,
    output logic            stable_out
);

    logic [31:0] tick_r;
    logic [31:0] tick_nxt;
    logic [7:0]  left_r;
    logic [7:0]  left_nxt;
    logic        busy_r;
    logic        busy_nxt;
    logic        stable_r;
    logic        stable_nxt;

    // ==========================================================
    // Countdown in 2 ms units
    // ==========================================================
    always_comb
    begin
        tick_nxt   = tick_r;
        left_nxt   = left_r;
        busy_nxt   = busy_r;
        stable_nxt = 1'b0;
        if (start_in)
        begin
            tick_nxt = 32'h0;
            left_nxt = units_in;
            busy_nxt = (units_in != 8'h00);
            stable_nxt = (units_in == 8'h00);
        end
        else if (busy_r)
        begin
            if (tick_r == 32'(UNIT_CYC - 1))
            begin
                tick_nxt = 32'h0;
                left_nxt = left_r - 8'h01;
                if (left_r == 8'h01)
                begin
                    busy_nxt   = 1'b0;
                    stable_nxt = 1'b1;
                end
            end
            else
            begin
                tick_nxt = tick_r + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            tick_r   <= 32'h0;
            left_r   <= 8'h00;
            busy_r   <= 1'b0;
            stable_r <= 1'b0;
        end
        else
        begin
            tick_r   <= tick_nxt;
            left_r   <= left_nxt;
            busy_r   <= busy_nxt;
            stable_r <= stable_nxt;
        end
    end

    assign busy_out   = busy_r;
    assign stable_out = stable_r;

endmodule
`default_nettype wire

//--- bench/cfg_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none

module cfg_bank_sva (
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    input  wire cfg_bank_pkg::cfg_wr_t   cfg_wr_in,
    input  wire logic [7:0]              cfg_rd_addr_in,
    input  wire logic [7:0]              cfg_rd_data_out,
    input  wire logic                    port_power_start_in,
    input  wire logic                    port_power_busy_out,
    input  wire logic                    port_power_stable_out,
    input  wire cfg_bank_pkg::cfg_view_t cfg_view_out,
    input  wire logic                    text_req_in,
    input  wire logic                    text_ready_in,
    input  wire logic                    text_valid_out,
    input  wire logic [15:0]             text_char_out,
    input  wire logic                    text_last_out
);
    // ====================
    // Checks
    // ====================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Three quiet cycles let the registered view catch up
    sequence quiet;
        (!cfg_wr_in.wr)[*3];
    endsequence

    a_unmapped_zero:
        assert property ((cfg_rd_addr_in < 8'h0f || cfg_rd_addr_in > 8'h53) |=>
            cfg_rd_data_out == 8'h00) else $error("unmapped read not zero");
    a_ma_double:
        assert property (cfg_view_out.current_ma ==
            10'(cfg_view_out.current_units) * 10'(cfg_bank_pkg::CURRENT_UNIT_MA))
        else $error("current in mA not twice the units");
    a_reset_current:
        assert property ($fell(sys_rst_in) |-> cfg_view_out.current_units == 8'h32)
        else $error("current byte not 50 after reset");
    a_lang_high:
        assert property (quiet ##0 cfg_rd_addr_in == 8'h11 |=>
            cfg_rd_data_out == cfg_view_out.language_id[15:8]) else $error("id high mismatch");
    a_lang_low:
        assert property (quiet ##0 cfg_rd_addr_in == 8'h12 |=>
            cfg_rd_data_out == cfg_view_out.language_id[7:0]) else $error("id low mismatch");
    a_start_busy:
        assert property (port_power_start_in && cfg_view_out.settle_units != 8'h00 |=>
            port_power_busy_out) else $error("settle count did not start");
    a_settle_end:
        assert property ($fell(port_power_busy_out) |-> port_power_stable_out)
        else $error("settle end without stable pulse");
    a_char_hold:
        assert property (text_valid_out && !text_ready_in |=> text_valid_out &&
            $stable(text_char_out) && $stable(text_last_out)) else $error("char not held");
    a_last_drop:
        assert property (text_valid_out && text_ready_in && text_last_out |=> !text_valid_out)
        else $error("stream ran past last char");
    a_req_starts:
        assert property (text_req_in && !text_valid_out && cfg_view_out.maker_len != 8'h00
            |=> text_valid_out) else $error("stream did not start");

    c_stable: cover property (port_power_stable_out);
    c_last: cover property (text_valid_out && text_ready_in && text_last_out);
    c_stall: cover property (text_valid_out && !text_ready_in);
endmodule

bind hub_power_and_string_config_bank cfg_bank_sva u_sva (.*);

`default_nettype wire

//--- bench/cfg_loader.sv
`timescale 1ns/1ps
`default_nettype none

module cfg_loader (
    input  wire logic                clk_in,
    output var cfg_bank_pkg::cfg_wr_t cfg_wr_out
);
    // ====================
    // Byte writer
    // ====================
    // Current byte written covers hub only, embedded draw left out
    // Lengths kept to 31 except where clamping is probed
    initial cfg_wr_out = '0;

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        cfg_wr_out = '{wr: 1'b1, addr: a, data: d};
        @(negedge clk_in);
        // Released lines show the inverse, never the old value
        cfg_wr_out = '{wr: 1'b0, addr: ~a, data: ~d};
    endtask

    task automatic put_char(input logic [7:0] n, input logic [15:0] ch);
        put(8'h16 + 8'(2 * n), ch[7:0]);
        put(8'h17 + 8'(2 * n), ch[15:8]);
    endtask
endmodule

`default_nettype wire

//--- bench/hub_power_and_string_config_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none

module hub_power_and_string_config_bank_bench;
    // ====================
    // Harness
    // ====================
    logic                    clk_in = 1'b0;
    logic                    sys_rst_in = 1'b1;
    logic [7:0]              rd_addr = 8'h00;
    logic [7:0]              rd_data;
    logic                    start = 1'b0;
    logic                    busy;
    logic                    stable;
    logic                    req = 1'b0;
    logic                    ready = 1'b0;
    logic                    text_valid;
    logic [15:0]             text_char;
    logic                    text_last;
    cfg_bank_pkg::cfg_wr_t   wr_bus;
    cfg_bank_pkg::cfg_view_t view;
    int                      err_total = 0;
    int                      check_count = 0;
    int                      n;

    always #25 clk_in = ~clk_in;

    cfg_loader u_load (.clk_in(clk_in), .cfg_wr_out(wr_bus));

    hub_power_and_string_config_bank u_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_wr_in(wr_bus),
        .cfg_rd_addr_in(rd_addr), .cfg_rd_data_out(rd_data),
        .port_power_start_in(start), .port_power_busy_out(busy),
        .port_power_stable_out(stable), .cfg_view_out(view),
        .text_req_in(req), .text_ready_in(ready), .text_valid_out(text_valid),
        .text_char_out(text_char), .text_last_out(text_last)
    );

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        rd_addr = a;
        @(negedge clk_in);
        chk("read", {8'h00, rd_data}, {8'h00, exp});
    endtask

    // One-cycle start pulse for the settle timer
    task automatic kick;
        @(negedge clk_in);
        start = 1'b1;
        @(negedge clk_in);
        start = 1'b0;
    endtask

    // Ready toggles so every char also sees a stall
    task automatic stream(input int cnt);
        int         got;
        logic [7:0] lo;
        got = 0;
        @(negedge clk_in);
        req = 1'b1;
        @(negedge clk_in);
        req = 1'b0;
        for (int i = 0; i < 200 && (text_valid === 1'b1 || got == 0); i++)
        begin
            ready = i[0];
            if (text_valid === 1'b1 && ready)
            begin
                lo = 8'h16 + 8'(2 * got);
                chk("char", text_char, {lo + 8'h01, lo});
                chk("last", {15'h0, text_last}, {15'h0, got == cnt - 1});
                got++;
            end
            @(negedge clk_in);
        end
        ready = 1'b0;
        chk("count", 16'(got), 16'(cnt));
    endtask

    task automatic print_verdict;
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Settle test alone needs 40000 cycles
    initial
    begin
        #(60000 * 50);
        err_total++;
        print_verdict;
    end

    initial
    begin
        repeat (12) @(negedge clk_in);
        sys_rst_in = 1'b0;
        rdc(8'h0f, 8'h32);
        chk("ma", {6'h00, view.current_ma}, 16'h0064);
        rdc(8'h10, 8'h00);
        u_load.put(8'h0f, 8'h7d);
        rdc(8'h0f, 8'h7d);
        chk("ma", {6'h00, view.current_ma}, 16'h00fa);
        u_load.put(8'h11, 8'h04);
        u_load.put(8'h12, 8'h09);
        rdc(8'h11, 8'h04);
        rdc(8'h12, 8'h09);
        chk("lang", view.language_id, 16'h0409);
        u_load.put(8'h14, 8'h1f);
        u_load.put(8'h15, 8'h1e);
        rdc(8'h14, 8'h1f);
        rdc(8'h15, 8'h1e);
        chk("prod", {8'h00, view.product_len}, 16'h001f);
        chk("serial", {8'h00, view.serial_len}, 16'h001e);
        for (int c = 0; c < 31; c++)
            u_load.put_char(8'(c), {8'h17 + 8'(2 * c), 8'h16 + 8'(2 * c)});
        rdc(8'h16, 8'h16);
        rdc(8'h53, 8'h53);
        rdc(8'h54, 8'h00);
        rdc(8'h0e, 8'h00);
        u_load.put(8'h13, 8'h03);
        rdc(8'h13, 8'h03);
        chk("mlen", {8'h00, view.maker_len}, 16'h0003);
        stream(3);
        u_load.put(8'h13, 8'h00);
        stream(0);
        u_load.put(8'h13, 8'h28);
        stream(31);
        // Zero settle count: stable one cycle after start, never busy
        kick;
        chk("zero", {15'h0, stable}, 16'h0001);
        chk("nobusy", {15'h0, busy}, 16'h0000);
        u_load.put(8'h10, 8'h01);
        chk("units", {8'h00, view.settle_units}, 16'h0001);
        kick;
        chk("busy", {15'h0, busy}, 16'h0001);
        n = 0;
        while (stable !== 1'b1 && n < 50000)
        begin
            @(negedge clk_in);
            n++;
        end
        chk("settle", 16'(n), 16'h9c40);
        chk("idle", {15'h0, busy}, 16'h0000);
        // Second reset mid-run must bring the defaults back
        @(negedge clk_in);
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        rdc(8'h0f, 8'h32);
        chk("ma", {6'h00, view.current_ma}, 16'h0064);
        rdc(8'h13, 8'h00);
        print_verdict;
    end
endmodule

`default_nettype wire
